// File: clock_reset_strap_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module clock_reset_strap_control_tb;
    logic clk_sys_i = 1'b0, reset_n_i = 1'b0, chip_reset_n_i = 1'b0;
    logic test_reset_n_i = 1'b1, wdt_expire_i = 1'b0, cpu_l = 1'b0;
    logic uart_rts_n_fn_i = 1'b1, static_oe_n_fn_i = 1'b1, pol_l = 1'b0;
    logic ref_clock_in_i, cpu_clock_source_strap_i, reset_out_polarity_strap_i;
    logic uart_request_to_send_n_o, uart_request_to_send_n_oe_o;
    logic static_output_enable_n_o, static_output_enable_n_oe_o;
    logic system_reset_out_o, system_reset_out_oe_o, core_reset_n_o;
    logic test_logic_reset_n_o, cpu_clock_use_pll_o, cpu_clock_reserved_o;
    logic ref_clock_alive_o, tx_clock_from_ref_o, pll_ref_enable_o;
    int miscompares = 0, tests_run = 0;
    // stretch cut to 50 cycles to keep the run short
    crsc_top #(.RSTOUT_CYC(23'h00_0032)) u_dut (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .chip_reset_n_i(chip_reset_n_i), .ref_clock_in_i(ref_clock_in_i),
        .test_reset_n_i(test_reset_n_i),
        .cpu_clock_source_strap_i(cpu_clock_source_strap_i),
        .reset_out_polarity_strap_i(reset_out_polarity_strap_i),
        .wdt_expire_i(wdt_expire_i), .uart_rts_n_fn_i(uart_rts_n_fn_i),
        .static_oe_n_fn_i(static_oe_n_fn_i),
        .uart_request_to_send_n_o(uart_request_to_send_n_o),
        .uart_request_to_send_n_oe_o(uart_request_to_send_n_oe_o),
        .static_output_enable_n_o(static_output_enable_n_o),
        .static_output_enable_n_oe_o(static_output_enable_n_oe_o),
        .system_reset_out_o(system_reset_out_o),
        .system_reset_out_oe_o(system_reset_out_oe_o),
        .core_reset_n_o(core_reset_n_o),
        .test_logic_reset_n_o(test_logic_reset_n_o),
        .cpu_clock_use_pll_o(cpu_clock_use_pll_o),
        .cpu_clock_reserved_o(cpu_clock_reserved_o),
        .ref_clock_alive_o(ref_clock_alive_o),
        .tx_clock_from_ref_o(tx_clock_from_ref_o),
        .pll_ref_enable_o(pll_ref_enable_o));
    crsc_board u_board (.cpu_i(cpu_l), .pol_i(pol_l),
        .rts_i(uart_request_to_send_n_o),
        .rts_oe_i(uart_request_to_send_n_oe_o),
        .oen_i(static_output_enable_n_o),
        .oen_oe_i(static_output_enable_n_oe_o), .ref_o(ref_clock_in_i),
        .cpu_o(cpu_clock_source_strap_i),
        .pol_o(reset_out_polarity_strap_i));
    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic chk(input logic s, input logic e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %0t bad level", $time);
        end
    endtask
    task automatic test_done;
        if (miscompares == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wt(ref logic s, input logic v);
        for (int n = 0; n < 20 && s !== v; n++)
            cyc(1);
        if (s !== v) begin
            miscompares++;
            test_done;
        end
    endtask
    task automatic t_release(input logic c, input logic p);
        cpu_l = c;
        pol_l = p;
        chip_reset_n_i = 1'b0;
        // sync, filter and 256-cycle count land re-entry two cycles later
        cyc(262);
        chk(static_output_enable_n_oe_o | system_reset_out_oe_o, 1'b0);
        chk(uart_request_to_send_n_oe_o, 1'b0);
        chk(core_reset_n_o, 1'b0);
        chip_reset_n_i = 1'b1;
        wt(system_reset_out_oe_o, 1'b1);
        chk(cpu_clock_use_pll_o, ~c);
        chk(system_reset_out_o, ~p);
        uart_rts_n_fn_i = ~c;
        static_oe_n_fn_i = ~p;
        cyc(2);
        chk(uart_request_to_send_n_o, ~c);
        chk(static_output_enable_n_o, ~p);
        chk(cpu_clock_reserved_o, c);
        cyc(55);
        chk(system_reset_out_o, p);
    endtask
    task automatic t_wdt;
        wdt_expire_i = 1'b1;
        cyc(1);
        wdt_expire_i = 1'b0;
        wt(core_reset_n_o, 1'b0);
        cyc(42);
        chk(system_reset_out_o, ~pol_l);
        cyc(20);
        chk(system_reset_out_o, pol_l);
    endtask
    task automatic t_short;
        chip_reset_n_i = 1'b0;
        test_reset_n_i = 1'b0;
        // just short of the valid hold: pins must still be driven
        cyc(250);
        chk(test_logic_reset_n_o, 1'b0);
        chk(system_reset_out_oe_o, 1'b1);
        chip_reset_n_i = 1'b1;
        test_reset_n_i = 1'b1;
        cyc(8);
        chk(system_reset_out_oe_o & test_logic_reset_n_o, 1'b1);
        chk(tx_clock_from_ref_o & pll_ref_enable_o, 1'b1);
        chk(ref_clock_alive_o, 1'b1);
    endtask
    initial begin
        cyc(4);
        reset_n_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            t_release(i[1], i[0]);
            t_wdt();
        end
        t_short();
        test_done();
    end
endmodule // clock_reset_strap_control_tb
`default_nettype wire

// File: crsc_board.sv
`timescale 1ns/1ps
`default_nettype none
module crsc_board (
    input wire logic cpu_i,
    input wire logic pol_i,
    input wire logic rts_i,
    input wire logic rts_oe_i,
    input wire logic oen_i,
    input wire logic oen_oe_i,
    output logic ref_o,
    output wire logic cpu_o,
    output wire logic pol_o
);
    // free-running 25 MHz oscillator
    initial begin
        ref_o = 1'b0;
        forever #20 ref_o = ~ref_o;
    end
    // strap resistor holds a defined level until the device drives
    assign cpu_o = rts_oe_i ? rts_i : cpu_i;
    assign pol_o = oen_oe_i ? oen_i : pol_i;
endmodule // crsc_board
`default_nettype wire

// File: crsc_defs.vh
`ifndef CRSC_DEFS_VH
`define CRSC_DEFS_VH

// system clock rate in kHz (40 MHz, 25 ns period)
`define CRSC_CLK_KHZ 40000
// shortest hold of the chip reset input, in system clock cycles
`define CRSC_CHIP_RST_MIN_CYC 9'h100
// last count before the hold is long enough, sized to the counter
`define CRSC_CHIP_RST_LAST 9'h0FF
`define CRSC_CHIP_RST_CNT_W 9
// least stretch of the system reset output, in milliseconds
`define CRSC_RSTOUT_MIN_MS 200
// 200 ms at 40 MHz, sized to the stretch counter
`define CRSC_RSTOUT_CYC 23'h7A_1200
`define CRSC_RSTOUT_CNT_W 23
// cycles without a reference edge before the reference counts as dead
`define CRSC_REF_TIMEOUT_CYC 5'h10
`define CRSC_REF_CNT_W 5

// bit positions of the synchronised pin vector
`define CRSC_PIN_W 5
`define CRSC_PIN_CHIP_RST 0
`define CRSC_PIN_CPU_STRAP 1
`define CRSC_PIN_POL_STRAP 2
`define CRSC_PIN_REF_CLK 3
`define CRSC_PIN_TRST 4
// pin reset levels: chip and test reset read asserted until synced
`define CRSC_PIN_RST 5'h08

// strap reset values, held until the first release is seen
`define CRSC_CPU_STRAP_RST 1'h0
`define CRSC_POL_STRAP_RST 1'h0

`endif

// File: crsc_reset_stretch.v
`timescale 1ns/1ps
`default_nettype none
`include "crsc_defs.vh"

// holds its output for a fixed count after the trigger level drops
module crsc_reset_stretch #(
    parameter [`CRSC_RSTOUT_CNT_W-1:0] STRETCH_CYC = `CRSC_RSTOUT_CYC
) (
    input wire clk_sys_i,
    input wire reset_n_i,
    input wire trig_i,
    output reg active_o
);

reg [`CRSC_RSTOUT_CNT_W-1:0] cnt_q;

// counter reloads while triggered, so a new event restarts the stretch
always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        cnt_q <= {`CRSC_RSTOUT_CNT_W{1'b0}};
        active_o <= 1'b1;
    end else if (trig_i) begin
        cnt_q <= STRETCH_CYC;
        active_o <= 1'b1;
    end else if (cnt_q > {{(`CRSC_RSTOUT_CNT_W-1){1'b0}}, 1'b1}) begin
        cnt_q <= cnt_q - {{(`CRSC_RSTOUT_CNT_W-1){1'b0}}, 1'b1};
        active_o <= 1'b1;
    end else begin
        cnt_q <= {`CRSC_RSTOUT_CNT_W{1'b0}};
        active_o <= 1'b0;
    end
end

endmodule // crsc_reset_stretch
`default_nettype wire

// File: crsc_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "crsc_defs.vh"
module crsc_sva #(
    parameter [`CRSC_RSTOUT_CNT_W-1:0] RSTOUT_CYC = `CRSC_RSTOUT_CYC
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic cpu_clock_source_strap_i,
    input wire logic reset_out_polarity_strap_i,
    input wire logic wdt_expire_i,
    input wire logic uart_request_to_send_n_oe_o,
    input wire logic system_reset_out_o,
    input wire logic system_reset_out_oe_o,
    input wire logic core_reset_n_o,
    input wire logic cpu_clock_reserved_o
);
    wire logic oe = system_reset_out_oe_o;
    wire logic rst = system_reset_out_o;
    wire logic rsv = cpu_clock_reserved_o;
    wire logic wdt = wdt_expire_i && oe;
    logic oe_q, lvl_q;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);
    // asserted level caught on the first driven cycle, polarity unknown here
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            oe_q <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            oe_q <= oe;
            lvl_q <= (oe && !oe_q) ? rst : lvl_q;
        end
    end
    a_pins_agree: assert property (oe == uart_request_to_send_n_oe_o)
        else $error("oe split");
    a_cpu_strap: assert property ($rose(oe) |=>
        rsv == $past(cpu_clock_source_strap_i, 3)) else $error("cpu strap");
    a_pol_strap: assert property ($rose(oe) |=>
        rst != $past(reset_out_polarity_strap_i, 3)) else $error("polarity");
    a_strap_hold: assert property (oe [*3] |-> $stable(rsv))
        else $error("strap moved");
    a_rel_hold: assert property ($rose(oe) |=> (rst == lvl_q) [*8])
        else $error("release short");
    a_wdt_core: assert property (wdt |-> ##2 !core_reset_n_o)
        else $error("core reset");
    a_wdt_hold: assert property (wdt |-> ##3 (rst == lvl_q) [*8])
        else $error("stretch short");
    a_wdt_end: assert property (wdt |-> ##[40:70] rst != lvl_q)
        else $error("stretch long");
    c_release: cover property ($rose(oe));
    c_reenter: cover property ($fell(oe));
    c_wdt: cover property (wdt);
endmodule // crsc_sva
bind crsc_top crsc_sva #(.RSTOUT_CYC(RSTOUT_CYC)) u_sva (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .cpu_clock_source_strap_i(cpu_clock_source_strap_i),
    .reset_out_polarity_strap_i(reset_out_polarity_strap_i),
    .wdt_expire_i(wdt_expire_i),
    .uart_request_to_send_n_oe_o(uart_request_to_send_n_oe_o),
    .system_reset_out_o(system_reset_out_o),
    .system_reset_out_oe_o(system_reset_out_oe_o),
    .core_reset_n_o(core_reset_n_o),
    .cpu_clock_reserved_o(cpu_clock_reserved_o)
);
`default_nettype wire

// File: crsc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "crsc_defs.vh"

module crsc_top #(
    parameter [`CRSC_RSTOUT_CNT_W-1:0] RSTOUT_CYC = `CRSC_RSTOUT_CYC
) (
    input wire clk_sys_i,
    input wire reset_n_i,
    // board pins, asynchronous to clk_sys_i
    input wire chip_reset_n_i,
    input wire ref_clock_in_i,
    input wire test_reset_n_i,
    input wire cpu_clock_source_strap_i,
    input wire reset_out_polarity_strap_i,
    // same-domain functional sources
    input wire wdt_expire_i,
    input wire uart_rts_n_fn_i,
    input wire static_oe_n_fn_i,
    // shared strap pins, output side
    output reg uart_request_to_send_n_o,
    output reg uart_request_to_send_n_oe_o,
    output reg static_output_enable_n_o,
    output reg static_output_enable_n_oe_o,
    // reset output pin
    output reg system_reset_out_o,
    output reg system_reset_out_oe_o,
    // internal controls
    output reg core_reset_n_o,
    output reg test_logic_reset_n_o,
    output reg cpu_clock_use_pll_o,
    output reg cpu_clock_reserved_o,
    output reg ref_clock_alive_o,
    output reg tx_clock_from_ref_o,
    output reg pll_ref_enable_o
);

localparam [1:0] ST_RESET = 2'b01;
localparam [1:0] ST_RUN = 2'b10;
// a high reset level on the chip reset bit would fake an early release
localparam [`CRSC_PIN_W-1:0] PIN_RST = `CRSC_PIN_RST;

// filtered pin value takes a change only once stages two and three agree
function [`CRSC_PIN_W-1:0] agree_filter;
    input [`CRSC_PIN_W-1:0] s2;
    input [`CRSC_PIN_W-1:0] s3;
    input [`CRSC_PIN_W-1:0] prev;
    begin
        agree_filter = (s2 & s3) | (prev & (s2 ^ s3));
    end
endfunction

wire [`CRSC_PIN_W-1:0] pin_raw;
reg [`CRSC_PIN_W-1:0] sync1_q;
reg [`CRSC_PIN_W-1:0] sync2_q;
reg [`CRSC_PIN_W-1:0] sync3_q;
reg [`CRSC_PIN_W-1:0] flt_q;
reg [1:0] state_q;
reg [1:0] state_d;
reg [`CRSC_CHIP_RST_CNT_W-1:0] low_cnt_q;
reg cpu_strap_q;
reg pol_strap_q;
reg ref_prev_q;
reg [`CRSC_REF_CNT_W-1:0] ref_idle_q;
reg wdt_q;
wire chip_rst_low;
wire low_long;
wire release_now;
wire ref_edge;
wire stretch_active;
wire in_reset;

assign pin_raw[`CRSC_PIN_CHIP_RST] = chip_reset_n_i;
assign pin_raw[`CRSC_PIN_CPU_STRAP] = cpu_clock_source_strap_i;
assign pin_raw[`CRSC_PIN_POL_STRAP] = reset_out_polarity_strap_i;
assign pin_raw[`CRSC_PIN_REF_CLK] = ref_clock_in_i;
assign pin_raw[`CRSC_PIN_TRST] = test_reset_n_i;

// three-stage synchroniser per pin; stage one feeds only stage two
genvar gi;
generate
    for (gi = 0; gi < `CRSC_PIN_W; gi = gi + 1) begin : g_sync
        always @(posedge clk_sys_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                sync1_q[gi] <= PIN_RST[gi];
                sync2_q[gi] <= PIN_RST[gi];
                sync3_q[gi] <= PIN_RST[gi];
            end else begin
                sync1_q[gi] <= pin_raw[gi];
                sync2_q[gi] <= sync1_q[gi];
                sync3_q[gi] <= sync2_q[gi];
            end
        end
    end
endgenerate

// agreement filter, rejects a single-cycle disagreement
always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        flt_q <= PIN_RST;
    end else begin
        flt_q <= agree_filter(sync2_q, sync3_q, flt_q);
    end
end

assign chip_rst_low = ~flt_q[`CRSC_PIN_CHIP_RST];

// a shorter low pulse is a glitch and does not reset the chip
assign low_long = (low_cnt_q == `CRSC_CHIP_RST_LAST);

// count how long chip reset has been low, saturating at the last count before the minimum
always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        low_cnt_q <= {`CRSC_CHIP_RST_CNT_W{1'b0}};
    end else if (!chip_rst_low) begin
        low_cnt_q <= {`CRSC_CHIP_RST_CNT_W{1'b0}};
    end else if (!low_long) begin
        low_cnt_q <= low_cnt_q + {{(`CRSC_CHIP_RST_CNT_W-1){1'b0}}, 1'b1};
    end
end

// power-on starts in reset; release waits for the pin to read high
always @* begin
    state_d = state_q;
    case (state_q)
        ST_RESET: begin
            if (!chip_rst_low) begin
                state_d = ST_RUN;
            end
        end
        ST_RUN: begin
            if (chip_rst_low && low_long) begin
                state_d = ST_RESET;
            end
        end
        default: begin
            state_d = ST_RESET;
        end
    endcase
end

always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        state_q <= ST_RESET;
    end else begin
        state_q <= state_d;
    end
end

assign in_reset = (state_q == ST_RESET);
assign release_now = in_reset && (state_d == ST_RUN);

// straps captured on release and frozen until the next release
always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        cpu_strap_q <= `CRSC_CPU_STRAP_RST;
        pol_strap_q <= `CRSC_POL_STRAP_RST;
    end else if (release_now) begin
        cpu_strap_q <= flt_q[`CRSC_PIN_CPU_STRAP];
        pol_strap_q <= flt_q[`CRSC_PIN_POL_STRAP];
    end
end

// reference activity: any edge within the timeout keeps it alive
assign ref_edge = flt_q[`CRSC_PIN_REF_CLK] ^ ref_prev_q;

always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        ref_prev_q <= 1'b1;
        ref_idle_q <= {`CRSC_REF_CNT_W{1'b0}};
    end else begin
        ref_prev_q <= flt_q[`CRSC_PIN_REF_CLK];
        if (ref_edge) begin
            ref_idle_q <= {`CRSC_REF_CNT_W{1'b0}};
        end else if (ref_idle_q != `CRSC_REF_TIMEOUT_CYC) begin
            ref_idle_q <= ref_idle_q + {{(`CRSC_REF_CNT_W-1){1'b0}}, 1'b1};
        end
    end
end

// watchdog pulse held one cycle so the stretcher sees it registered
always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        wdt_q <= 1'b0;
    end else begin
        wdt_q <= wdt_expire_i && !in_reset;
    end
end

crsc_reset_stretch #(
    .STRETCH_CYC(RSTOUT_CYC)
) u_stretch (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .trig_i(in_reset | wdt_q),
    .active_o(stretch_active)
);

// pin drivers; every pin floats while the chip is held in reset
always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        uart_request_to_send_n_o <= 1'b1;
        uart_request_to_send_n_oe_o <= 1'b0;
        static_output_enable_n_o <= 1'b1;
        static_output_enable_n_oe_o <= 1'b0;
        system_reset_out_o <= 1'b0;
        system_reset_out_oe_o <= 1'b0;
    end else begin
        uart_request_to_send_n_o <= uart_rts_n_fn_i;
        uart_request_to_send_n_oe_o <= !in_reset;
        static_output_enable_n_o <= static_oe_n_fn_i;
        static_output_enable_n_oe_o <= !in_reset;
        // strap low: asserted is high; strap high: asserted is low
        system_reset_out_o <= stretch_active ^ pol_strap_q;
        system_reset_out_oe_o <= !in_reset;
    end
end

// internal controls; the strap value only matters once latched
always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        core_reset_n_o <= 1'b0;
        test_logic_reset_n_o <= 1'b0;
        cpu_clock_use_pll_o <= 1'b1;
        cpu_clock_reserved_o <= 1'b0;
        ref_clock_alive_o <= 1'b0;
        tx_clock_from_ref_o <= 1'b1;
        pll_ref_enable_o <= 1'b1;
    end else begin
        core_reset_n_o <= !in_reset && !wdt_q;
        test_logic_reset_n_o <= flt_q[`CRSC_PIN_TRST];
        cpu_clock_use_pll_o <= !cpu_strap_q;
        cpu_clock_reserved_o <= cpu_strap_q;
        ref_clock_alive_o <= (ref_idle_q != `CRSC_REF_TIMEOUT_CYC);
        tx_clock_from_ref_o <= 1'b1;
        pll_ref_enable_o <= 1'b1;
    end
end

endmodule // crsc_top
`default_nettype wire
